// *** include/dram_crc_link_if.sv ***
// link between write-checksum controller and memory device
`timescale 1ns/1ps
interface dram_crc_link_if;
  logic link_clk;
  logic frame;
  logic [15:0] dq;
  logic [1:0] mask_lane;
  logic alert_o;
  logic alert_oe;
  logic alert_n;

  // open-drain alert, pulled high when nobody drives
  assign alert_n = (alert_oe && !alert_o) ? 1'b0 : 1'b1;

  modport ctrl (
    output link_clk,
    output frame,
    output dq,
    output mask_lane,
    input alert_n
  );
  modport dev (
    input link_clk,
    input frame,
    input dq,
    input mask_lane,
    output alert_o,
    output alert_oe
  );
endinterface

// *** include/dram_crc_pkg.sv ***
// shared constants and checksum logic for the write-checksum link
// Behaviour
// [R01] controller appends checksum over 72-bit word
// [R02] four-bit width: bits 71..32 forced ones
// [R03] eight-bit width: top lane mask/inversion else ones
// [R04] sixteen-bit: two independent identical checksum trees
// [R05] controller sends ones in tenth beat; in x4 lanes 3..0 carry checksum bits 7..4 there instead
// [R06] device compares, asserts active-low alert on mismatch
// [R07] no masking: write commits before check
// [R08] masking plus checksum: failed write dropped
// [R09] failed auto-close write still precharges
// [R10] checksum on raw data, inversion corrected after
// [R11] controller never enables write inversion with masking
// [R12] one-clock preamble: no column spacing of four
// [R13] two-clock preamble: no column spacing of six
// [R14] no multipurpose writes, no per-device mode
// [R15] polynomial x^8+x^2+x+1, parallel xor logic
// [R16] bit 71 first, initial state zero
// [R17] detects single, double, odd and column errors
// [R18] upper tree protects bits 143..72
// [R19] fixed burst order, low column bits zero
// [R20] both ends share identical checksum equations
package dram_crc_pkg;
  localparam logic [1:0] WIDTH_X4 = 2'h0;
  localparam logic [1:0] WIDTH_X8 = 2'h1;
  localparam logic [1:0] WIDTH_X16 = 2'h2;
  localparam logic [3:0] BEATS_DATA = 4'h8;
  localparam logic [3:0] BEATS_CRC = 4'ha;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // timing
  localparam int PCLK_NS = 50;
  localparam int LINK_CLK_NS = 400;
  localparam logic [2:0] LINK_DIV_M1 = 3'(LINK_CLK_NS / PCLK_NS - 1);
  localparam logic [2:0] LINK_HALF = 3'(LINK_CLK_NS / PCLK_NS / 2);
  localparam int ALERT_NS = 400;
  localparam logic [3:0] ALERT_CYCLES =
    4'((ALERT_NS + PCLK_NS - 1) / PCLK_NS);
  // controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DATA0 = 8'h04;
  localparam logic [7:0] REG_LANE = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_CRC = 8'h1c;
  localparam int CTRL_START = 0;
  localparam int CTRL_WIDTH = 1;
  localparam int CTRL_CRC_EN = 3;
  localparam int CTRL_DM_EN = 4;
  localparam int CTRL_DBI_EN = 5;
  localparam int CTRL_INJECT = 6;
  localparam logic [5:0] CTRL_RESET = 6'h04;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ALERT = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_DONE = 3;

  // code word of one byte group
  function automatic logic [71:0] code_word(input logic [63:0] data,
                                            input logic [7:0] lane,
                                            input logic x4,
                                            input logic lane_used);
    logic [71:0] cw;
    cw = {(lane_used ? lane : 8'hff), data}; // [R03]
    if (x4) begin
      cw[71:32] = {40{1'b1}}; // [R02]
    end
    return cw;
  endfunction

  // parallel form of the serial divider, one equation set for both ends
  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT; // [R16]
    for (int i = 71; i >= 0; i--) begin // [R16]
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY; // [R15] [R20]
      end
    end
    return c;
  endfunction
endpackage

// *** src/dram_crc_ctrl.sv ***
// controller end: builds write frames with checksum, apb registers
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module dram_crc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dram_crc_link_if.ctrl link
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_SEND = 4'b0100,
    ST_GAP = 4'b1000
  } tx_state_e;

  tx_state_e state, next_state;
  logic [5:0] mode;
  logic [31:0] data_w [4];
  logic [15:0] lane_q;
  logic st_alert, st_refused, st_done;
  logic [15:0] crc_q;
  logic [2:0] ph;
  logic [3:0] tx_beat;
  logic [71:0] tx_cw [2];
  logic tx_x4, tx_x16, tx_crc_en;
  logic [1:0] alert_s;
  logic link_clk_q, frame_q;
  logic [15:0] dq_q;
  logic [1:0] ml_q;

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire sel_ctrl = paddr == dram_crc_pkg::REG_CTRL;
  wire sel_lane = paddr == dram_crc_pkg::REG_LANE;
  wire sel_stat = paddr == dram_crc_pkg::REG_STATUS;
  wire sel_crc = paddr == dram_crc_pkg::REG_CRC;
  wire [7:0] data_off = paddr - dram_crc_pkg::REG_DATA0;
  wire sel_data = paddr >= dram_crc_pkg::REG_DATA0
                  && paddr < dram_crc_pkg::REG_LANE
                  && paddr[1:0] == 2'h0;
  wire hit = sel_ctrl | sel_lane | sel_stat | sel_crc | sel_data;
  wire busy = state != ST_IDLE;
  wire [31:0] rd_value =
    sel_ctrl ? {25'h0, mode, 1'b0} :
    sel_data ? data_w[data_off[3:2]] :
    sel_lane ? {16'h0000, lane_q} :
    sel_stat ? {28'h0, st_done, st_refused, st_alert, busy} :
    sel_crc ? {16'h0000, crc_q} : 32'h0000_0000;

  // start carries its own mode; write inversion with masking is refused
  wire [5:0] new_mode = pwdata[6:1];
  wire conflict = pwdata[dram_crc_pkg::CTRL_DBI_EN]
                  & pwdata[dram_crc_pkg::CTRL_DM_EN]; // [R11]
  wire start_req = wr & sel_ctrl & pwdata[dram_crc_pkg::CTRL_START];
  wire start_ok = start_req & ~busy & ~conflict; // [R11]
  wire new_x4 = new_mode[1:0] == dram_crc_pkg::WIDTH_X4;
  wire new_lane_used = new_mode[3] | new_mode[4];
  wire [71:0] cw_lo = dram_crc_pkg::code_word({data_w[1], data_w[0]},
    lane_q[7:0], new_x4, new_lane_used); // [R01] [R02] [R03]
  wire [71:0] cw_hi = dram_crc_pkg::code_word({data_w[3], data_w[2]},
    lane_q[15:8], 1'b0, new_lane_used); // [R03]
  wire [7:0] crc_lo = dram_crc_pkg::crc8(cw_lo) ^ {7'h0, new_mode[5]};
  wire [7:0] crc_hi = dram_crc_pkg::crc8(cw_hi); // [R20]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      mode <= dram_crc_pkg::CTRL_RESET;
      lane_q <= 16'hffff;
    end else begin
      pready <= psel & ~penable;
      prdata <= rd_value;
      pslverr <= psel & ~penable & ~hit;
      if (wr && sel_ctrl && !busy) begin
        mode <= new_mode;
      end
      if (wr && sel_lane) begin
        lane_q <= pwdata[15:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_data
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          data_w[gi] <= 32'h0000_0000;
        end else if (wr && sel_data && data_off[3:2] == gi) begin
          data_w[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // status flags, set wins over write-one-to-clear
  // ------------------------------------------------------------
  wire upd = ph == dram_crc_pkg::LINK_HALF;
  wire clr = wr & sel_stat;
  wire frame_end = upd & (state == ST_GAP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_s <= 2'h3;
      st_alert <= 1'b0;
      st_refused <= 1'b0;
      st_done <= 1'b0;
    end else begin
      alert_s <= {alert_s[0], link.alert_n};
      st_alert <= ~alert_s[1]
        | (st_alert & ~(clr & pwdata[dram_crc_pkg::STAT_ALERT]));
      st_refused <= (start_req & ~start_ok)
        | (st_refused & ~(clr & pwdata[dram_crc_pkg::STAT_REFUSED]));
      st_done <= frame_end
        | (st_done & ~(clr & pwdata[dram_crc_pkg::STAT_DONE]));
    end
  end

  // ------------------------------------------------------------
  // link clock divider and frame builder
  // ------------------------------------------------------------
  wire [3:0] last_beat = tx_crc_en ? dram_crc_pkg::BEATS_CRC - 4'h1
                                   : dram_crc_pkg::BEATS_DATA - 4'h1;
  wire [3:0] nxt_beat = (state == ST_ARMED) ? 4'h0 : tx_beat + 4'h1;
  wire in_data = nxt_beat < dram_crc_pkg::BEATS_DATA;
  wire [15:0] beat_dq;
  wire [1:0] beat_ml;

  generate
    for (gi = 0; gi < 16; gi++) begin : g_dq
      localparam int G = gi / 8;
      localparam int J = gi % 8;
      wire unused = (G == 1 && !tx_x16) || (tx_x4 && J >= 4);
      wire b9;
      if (J < 4) begin : g_b9
        assign b9 = tx_x4 ? crc_q[J + 4] : 1'b1; // [R05]
      end else begin : g_one
        assign b9 = 1'b1; // [R05]
      end
      // beats run in fixed order, bit 8j+b on beat b
      assign beat_dq[gi] = unused ? 1'b1 :
        in_data ? tx_cw[G][J * 8 + {29'h0, nxt_beat[2:0]}] : // [R19]
        (nxt_beat == dram_crc_pkg::BEATS_DATA) ? crc_q[gi] : b9;
    end
    for (gi = 0; gi < 2; gi++) begin : g_ml
      assign beat_ml[gi] = (gi == 1 && !tx_x16) || !in_data ? 1'b1 :
        tx_cw[gi][64 + {29'h0, nxt_beat[2:0]}]; // [R05]
    end
  endgenerate

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_ok) next_state = ST_ARMED;
      ST_ARMED: if (upd) next_state = ST_SEND;
      ST_SEND: if (upd && tx_beat == last_beat) next_state = ST_GAP;
      // one idle beat keeps frame starts well apart from 4 or 6 clocks
      ST_GAP: if (upd) next_state = ST_IDLE; // [R12] [R13]
      default: next_state = ST_IDLE;
    endcase
  end

  // only write frames are ever sent, never other commands
  always_ff @(posedge pclk or negedge presetn) begin // [R14]
    if (!presetn) begin
      state <= ST_IDLE;
      ph <= 3'h0;
      link_clk_q <= 1'b0;
      frame_q <= 1'b0;
      dq_q <= 16'hffff;
      ml_q <= 2'h3;
      tx_beat <= 4'h0;
      crc_q <= 16'h0000;
      tx_cw[0] <= 72'h0;
      tx_cw[1] <= 72'h0;
      tx_x4 <= 1'b0;
      tx_x16 <= 1'b0;
      tx_crc_en <= 1'b0;
    end else begin
      state <= next_state;
      ph <= (ph == dram_crc_pkg::LINK_DIV_M1) ? 3'h0 : ph + 3'h1;
      link_clk_q <= ph < dram_crc_pkg::LINK_HALF;
      if (start_ok) begin
        crc_q <= {crc_hi, crc_lo};
        tx_cw[0] <= cw_lo;
        tx_cw[1] <= cw_hi;
        tx_x4 <= new_x4;
        tx_x16 <= new_mode[1:0] == dram_crc_pkg::WIDTH_X16;
        tx_crc_en <= new_mode[2];
      end
      if (upd && (state == ST_ARMED || state == ST_SEND)) begin
        if (state == ST_SEND && tx_beat == last_beat) begin
          frame_q <= 1'b0;
          dq_q <= 16'hffff;
          ml_q <= 2'h3;
        end else begin
          frame_q <= 1'b1;
          tx_beat <= nxt_beat;
          dq_q <= beat_dq;
          ml_q <= beat_ml;
        end
      end
    end
  end

  assign link.link_clk = link_clk_q;
  assign link.frame = frame_q;
  assign link.dq = dq_q;
  assign link.mask_lane = ml_q;
endmodule

// *** src/dram_crc_dev.sv ***
// memory device end: receives write frames and checks the checksum
`timescale 1ns/1ps
module dram_crc_dev (
  input wire logic pclk,
  input wire logic presetn,
  dram_crc_link_if.dev link,
  input wire logic [1:0] width_mode,
  input wire logic crc_en,
  input wire logic dm_en,
  input wire logic dbi_en,
  input wire logic autoclose,
  output logic wr_commit,
  output logic [127:0] wr_data,
  output logic [15:0] wr_byte_en,
  output logic precharge,
  output logic crc_error
);
  logic [2:0] clk_s;
  logic [1:0] frame_s;
  logic [15:0] dq_s1, dq_s2;
  logic [1:0] ml_s1, ml_s2;
  logic [3:0] beat;
  logic [7:0] sh [18];
  logic [15:0] crc_b8;
  logic [3:0] crc_b9;
  logic data_q, done_q;
  logic [3:0] alert_cnt;
  logic alert_oe_q;

  wire rise = clk_s[1] & ~clk_s[2];
  wire take = rise & frame_s[1];
  wire x4 = width_mode == dram_crc_pkg::WIDTH_X4;
  wire x16 = width_mode == dram_crc_pkg::WIDTH_X16;
  wire [3:0] last_beat = crc_en ? dram_crc_pkg::BEATS_CRC - 4'h1
                                : dram_crc_pkg::BEATS_DATA - 4'h1;
  wire [127:0] raw;
  wire [127:0] fixed;
  wire [15:0] ben;

  genvar gi;
  generate
    for (gi = 0; gi < 18; gi++) begin : g_lane
      wire bit_in = (gi < 16) ? dq_s2[gi % 16] : ml_s2[gi / 17];
      // beat b lands in bit b of each lane
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sh[gi] <= 8'h00;
        end else if (take && beat < dram_crc_pkg::BEATS_DATA) begin
          sh[gi] <= {bit_in, sh[gi][7:1]};
        end
      end
    end
    for (gi = 0; gi < 128; gi++) begin : g_bit
      localparam int G = gi / 64;
      localparam int L = (gi % 64) / 8;
      localparam int B = gi % 8;
      assign raw[gi] = sh[G * 8 + L][B];
      // inversion undone only after the checksum has seen raw data
      assign fixed[gi] = raw[gi] ^ (dbi_en & ~sh[16 + G][B]); // [R10]
    end
    for (gi = 0; gi < 16; gi++) begin : g_ben
      assign ben[gi] = ~dm_en | sh[16 + gi / 8][gi % 8];
    end
  endgenerate

  wire lane_used = dm_en | dbi_en;
  wire [71:0] cw_lo = dram_crc_pkg::code_word(raw[63:0], sh[16], x4,
                                              lane_used); // [R02] [R03]
  wire [71:0] cw_hi = dram_crc_pkg::code_word(raw[127:64], sh[17], 1'b0,
                                              lane_used); // [R18]
  wire [7:0] rx_lo = x4 ? {crc_b9, crc_b8[3:0]} : crc_b8[7:0];
  wire [7:0] rx_hi = crc_b8[15:8];
  // two independent trees, upper one only in the wide part
  wire bad_lo = dram_crc_pkg::crc8(cw_lo) != rx_lo; // [R04] [R06] [R17]
  wire bad_hi = x16 & (dram_crc_pkg::crc8(cw_hi) != rx_hi); // [R04] [R18]
  wire bad = crc_en & (bad_lo | bad_hi);
  wire early = data_q & ~(dm_en & crc_en); // [R07]
  wire late = done_q & dm_en & crc_en & ~bad; // [R08]

  // ------------------------------------------------------------
  // link sampling
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s <= 3'h0;
      frame_s <= 2'h0;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      ml_s1 <= 2'h0;
      ml_s2 <= 2'h0;
    end else begin
      clk_s <= {clk_s[1:0], link.link_clk};
      frame_s <= {frame_s[0], link.frame};
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
      ml_s1 <= link.mask_lane;
      ml_s2 <= ml_s1;
    end
  end

  // ------------------------------------------------------------
  // beat count and checksum beats
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat <= 4'h0;
      crc_b8 <= 16'h0000;
      crc_b9 <= 4'h0;
      data_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      data_q <= take && beat == dram_crc_pkg::BEATS_DATA - 4'h1;
      done_q <= take && beat == last_beat;
      if (!frame_s[1]) begin
        beat <= 4'h0;
      end else if (take) begin
        beat <= beat + 4'h1;
      end
      if (take && beat == dram_crc_pkg::BEATS_DATA) begin
        crc_b8 <= dq_s2;
      end
      if (take && beat == dram_crc_pkg::BEATS_DATA + 4'h1) begin
        crc_b9 <= dq_s2[3:0];
      end
    end
  end

  // ------------------------------------------------------------
  // array write, precharge and alert
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_commit <= 1'b0;
      wr_data <= 128'h0;
      wr_byte_en <= 16'h0000;
      precharge <= 1'b0;
      crc_error <= 1'b0;
      alert_cnt <= 4'h0;
      alert_oe_q <= 1'b0;
    end else begin
      wr_commit <= early | late; // [R07] [R08]
      if (early | late) begin
        wr_data <= fixed; // [R10]
        wr_byte_en <= ben;
      end
      precharge <= done_q & autoclose; // [R09]
      crc_error <= done_q & bad; // [R06]
      if (done_q && bad) begin
        alert_cnt <= dram_crc_pkg::ALERT_CYCLES; // [R06]
      end else if (alert_cnt != 4'h0) begin
        alert_cnt <= alert_cnt - 4'h1;
      end
      alert_oe_q <= (done_q & bad) | (alert_cnt > 4'h1);
    end
  end

  assign link.alert_o = 1'b0;
  assign link.alert_oe = alert_oe_q;
endmodule

// *** tb/dram_crc_properties.sv ***
// concurrent checks on the write-checksum link between the two ends
`timescale 1ns/1ps
module dram_crc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_clk,
  input wire logic frame,
  input wire logic [15:0] dq,
  input wire logic [1:0] mask_lane,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic alert_n
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [6:0] hi_cnt;
  logic [3:0] beat;
  logic [7:0] since_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 7'h00;
      beat <= 4'h0;
    end else if (!frame) begin
      hi_cnt <= 7'h00;
      beat <= 4'h0;
    end else begin
      hi_cnt <= hi_cnt + 7'h01;
      if ($rose(link_clk)) begin
        beat <= beat + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_fall <= 8'hff;
    end else if (frame) begin
      since_fall <= 8'h00;
    end else if (since_fall != 8'hff) begin
      since_fall <= since_fall + 8'h01;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence alert_hold;
    alert_oe [*8] ##1 !alert_oe;
  endsequence
  sequence clk_high;
    link_clk [*4];
  endsequence
  sequence clk_low;
    !link_clk [*4];
  endsequence

  chk_idle_lanes: assert property (
    !frame |-> dq == 16'hffff && mask_lane == 2'b11
      && alert_n == !(alert_oe && !alert_o))
    else $error("lanes not idle high outside a frame");
  chk_alert_length: assert property (
    $rose(alert_oe) |-> alert_hold)
    else $error("alert pulse length wrong");
  chk_alert_after_frame: assert property (
    $rose(alert_oe) |-> since_fall < 8'd16)
    else $error("alert raised without a recent frame");
  chk_frame_length: assert property (
    $fell(frame) |-> (hi_cnt == 7'd80 || hi_cnt == 7'd64))
    else $error("frame length wrong");
  chk_frame_gap: assert property (
    $fell(frame) |-> !frame [*8])
    else $error("idle gap between frames too short");
  chk_dq_stable: assert property (
    frame && link_clk && $past(link_clk) |-> $stable(dq) && $stable(mask_lane))
    else $error("data lanes moved while link clock high");
  chk_link_period: assert property (
    $rose(link_clk) |-> clk_high ##1 clk_low)
    else $error("link clock period wrong");
  chk_beat9_ones: assert property (
    frame && $rose(link_clk) && beat == 4'd9 |->
      dq[15:4] == 12'hfff && mask_lane == 2'b11)
    else $error("tenth beat not all ones");
  chk_beat8_lane: assert property (
    frame && $rose(link_clk) && beat == 4'd8 |-> mask_lane == 2'b11)
    else $error("mask lane not ones in checksum beat");
endmodule

// *** tb/testbench.sv ***
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] width_mode = 2'h1;
  logic crc_en = 1'b1;
  logic dm_en = 1'b0;
  logic dbi_en = 1'b0;
  logic autoclose = 1'b0;
  logic wr_commit;
  logic [127:0] wr_data;
  logic [15:0] wr_byte_en;
  logic [15:0] last_ben;
  logic precharge;
  logic crc_error;
  logic [127:0] last_wr;
  logic [31:0] st;
  logic [31:0] crc_rd;
  int errors = 0;
  int samples_checked = 0;
  int commits = 0;
  int fails = 0;
  int closes = 0;
  int c0;
  int f0;
  int p0;

  always #25 pclk = ~pclk;

  dram_crc_link_if lnk();
  dram_crc_ctrl dram_crc_ctrl_i(.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk));
  dram_crc_dev dram_crc_dev_i(.pclk(pclk), .presetn(presetn),
    .link(lnk), .width_mode(width_mode), .crc_en(crc_en),
    .dm_en(dm_en), .dbi_en(dbi_en), .autoclose(autoclose),
    .wr_commit(wr_commit), .wr_data(wr_data), .wr_byte_en(wr_byte_en),
    .precharge(precharge), .crc_error(crc_error));
  dram_crc_properties dram_crc_properties_i(.pclk(pclk),
    .presetn(presetn), .link_clk(lnk.link_clk), .frame(lnk.frame),
    .dq(lnk.dq), .mask_lane(lnk.mask_lane), .alert_o(lnk.alert_o),
    .alert_oe(lnk.alert_oe), .alert_n(lnk.alert_n));

  always @(posedge pclk) begin
    if (wr_commit === 1'b1) begin
      commits++;
      last_wr = wr_data;
      last_ben = wr_byte_en;
    end
    if (crc_error === 1'b1) fails++;
    if (precharge === 1'b1) closes++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] ref_crc(input logic [71:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], fb};
      c[1] = c[1] ^ fb;
      c[2] = c[2] ^ fb;
    end
    return c;
  endfunction

  function automatic logic [7:0] exp_crc(input logic [63:0] d,
                                         input logic [7:0] lane,
                                         input logic [5:0] m);
    logic [71:0] cw;
    cw = {((m[3] | m[4]) ? lane : 8'hff), d};
    if (m[1:0] == 2'h0) cw[71:32] = {40{1'b1}};
    return ref_crc(cw);
  endfunction

  task automatic check(input string name, input logic [127:0] seen,
                       input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout();
    errors++;
    $display("wait limit reached");
    test_done();
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) timeout();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask

  task automatic run_frame(input logic [5:0] m, input logic [127:0] d,
                           input logic [15:0] lane, input logic ac);
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h0000_0000;
    c0 = commits;
    f0 = fails;
    p0 = closes;
    width_mode <= m[1:0];
    crc_en <= m[2];
    dm_en <= m[3];
    dbi_en <= m[4];
    autoclose <= ac;
    for (int i = 0; i < 4; i++) wr(8'h04 + 8'(4 * i), d[32 * i +: 32]);
    wr(dram_crc_pkg::REG_LANE, {16'h0000, lane});
    wr(dram_crc_pkg::REG_CTRL, {25'h0, m, 1'b1});
    while (s[dram_crc_pkg::STAT_DONE] !== 1'b1 && n < 100) begin
      rd(dram_crc_pkg::REG_STATUS, s);
      n++;
    end
    if (n == 100) timeout();
    st = s;
    rd(dram_crc_pkg::REG_CRC, crc_rd);
    wr(dram_crc_pkg::REG_STATUS, 32'h0000_000e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(dram_crc_pkg::REG_CTRL, q);
    check("ctrl reset", q, 32'h0000_0008);
    rd(dram_crc_pkg::REG_LANE, q);
    check("lane reset", q, 32'h0000_ffff);
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    check("unmapped error", e, 1'b1);
    check("unmapped data", q, 32'h0000_0000);
    check("alert idle", lnk.alert_n, 1'b1);
  endtask

  task automatic t_x8_good();
    logic [63:0] d;
    d = 64'h0123_4567_89ab_cdef;
    run_frame(6'h05, {64'h0, d}, 16'h00a5, 1'b0);
    check("x8 crc", crc_rd[7:0], exp_crc(d, 8'ha5, 6'h05));
    check("x8 commit", 32'(commits - c0), 1);
    check("x8 no error", 32'(fails - f0), 0);
    check("x8 data", last_wr[63:0], d);
  endtask

  task automatic t_x4_good();
    logic [63:0] d;
    d = 64'h9876_0000_1234_5678;
    run_frame(6'h04, {64'h0, d}, 16'hffff, 1'b0);
    check("x4 crc", crc_rd[7:0], exp_crc(d, 8'hff, 6'h04));
    check("x4 no error", 32'(fails - f0), 0);
  endtask

  task automatic t_dm_err();
    run_frame(6'h0d, {64'h0, 64'h5555_aaaa_0f0f_f0f0}, 16'h00f0, 1'b0);
    check("dm good error", 32'(fails - f0), 0);
    check("dm good commit", 32'(commits - c0), 1);
    check("dm byte enables", last_ben, 16'hfff0);
    check("dm good data", last_wr[63:0], 64'h5555_aaaa_0f0f_f0f0);
    run_frame(6'h2d, {64'h0, 64'h5555_aaaa_0f0f_f0f0}, 16'h00f0, 1'b1);
    check("dm error", 32'(fails - f0), 1);
    check("dm blocked", 32'(commits - c0), 0);
    check("dm precharge", 32'(closes - p0), 1);
    check("dm alert seen", st[dram_crc_pkg::STAT_ALERT], 1'b1);
  endtask

  task automatic t_nodm_err();
    run_frame(6'h25, {64'h0, 64'h1111_2222_3333_4444}, 16'hffff, 1'b0);
    check("nodm error", 32'(fails - f0), 1);
    check("nodm commit", 32'(commits - c0), 1);
  endtask

  task automatic t_x16_dbi();
    logic [63:0] u;
    logic [63:0] l;
    u = 64'hcafe_f00d_0bad_beef;
    l = 64'h7654_3210_fedc_ba98;
    run_frame(6'h16, {u, l}, 16'hfffe, 1'b0);
    check("x16 crc", crc_rd[15:0], {exp_crc(u, 8'hff, 6'h16),
          exp_crc(l, 8'hfe, 6'h16)});
    check("x16 no error", 32'(fails - f0), 0);
    check("x16 data", last_wr, {u, l ^ 64'h0101_0101_0101_0101});
  endtask

  task automatic t_refused();
    logic [31:0] s;
    c0 = commits;
    wr(dram_crc_pkg::REG_CTRL, {25'h0, 6'h1d, 1'b1});
    rd(dram_crc_pkg::REG_STATUS, s);
    check("refused", s[dram_crc_pkg::STAT_REFUSED], 1'b1);
    check("refused no write", 32'(commits - c0), 0);
    wr(dram_crc_pkg::REG_STATUS, 32'h0000_000e);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_x8_good();
    t_x4_good();
    t_dm_err();
    t_nodm_err();
    t_x16_dbi();
    t_refused();
    test_done();
  end
endmodule
